// ---- i2cra_host_end.sv ----
// master end: makes the serial clock and runs single-byte transfers
`timescale 1ns/100ps
module i2cra_host_end
  import i2cra_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link side
  i2cra_link_if.host link,
  // command request
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire i2cra_cmd_t cmd_kind,
  input wire logic [SEL_W-1:0] cmd_sel,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_hold,
  input wire logic fast_mode,
  // answer
  output logic done,
  output logic nack,
  output logic [7:0] rd_data
);

  i2cra_host_state_t state_r;
  i2cra_cmd_t kind_r;
  i2cra_op_t op;
  logic [SEL_W-1:0] sel_r;
  logic [7:0] reg_r;
  logic [7:0] data_r;
  logic hold_r;
  logic fast_r;
  logic busy_r;
  logic [2:0] item_r;
  logic [2:0] last;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [TICK_W-1:0] tick_r;
  logic tick_end;
  logic q_end;
  logic op_end;
  logic [7:0] tx;
  logic [7:0] rx_r;
  logic nack_r;
  logic done_r;
  logic [7:0] rd_r;
  logic sda_meta_r;
  logic sda_r;
  logic scl_hi;
  logic sda_hi;
  logic scl_oe_r;
  logic sda_oe_r;

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe = scl_oe_r;
  assign link.host_sda_oe = sda_oe_r;
  assign cmd_ready = state_r == HST_IDLE;

  // item script per command kind
  always_comb begin
    op = OP_STOP;
    tx = {DEV_ADDR_HI, sel_r, RW_WRITE};
    last = LAST_WRITE;
    case (kind_r)
      CMD_READ: begin
        last = LAST_READ;
        tx = {DEV_ADDR_HI, sel_r, RW_READ};
        case (item_r)
          3'h0: op = OP_START;
          3'h1: op = OP_WBYTE;
          3'h2: op = OP_RBYTE;
          default: op = OP_STOP;
        endcase
      end
      default: begin
        last = (kind_r == CMD_SETPTR) ? LAST_SETPTR : LAST_WRITE;
        case (item_r)
          3'h0: op = OP_START;
          3'h1: op = OP_WBYTE;
          3'h2: begin
            op = OP_WBYTE;
            tx = reg_r;
          end
          3'h3: begin
            op = (kind_r == CMD_SETPTR) ? OP_STOP : OP_WBYTE;
            tx = data_r;
          end
          default: op = OP_STOP;
        endcase
      end
    endcase
  end

  // line levels per quarter of a bit; data moves only in quarter 0
  // while the clock is low, except the start and stop edges
  always_comb begin
    scl_hi = !busy_r;
    sda_hi = 1'b1;
    if (state_r == HST_RUN) begin
      scl_hi = q_r == 2'h1 || q_r == 2'h2;
      case (op)
        OP_START: begin
          scl_hi = (q_r == 2'h0) ? !busy_r : q_r != 2'h3;
          sda_hi = q_r[1] == 1'b0;
        end
        OP_WBYTE: sda_hi = bit_r == ACK_SLOT || tx[3'h7 - bit_r[2:0]];
        OP_RBYTE: sda_hi = bit_r != ACK_SLOT;
        OP_STOP: begin
          scl_hi = q_r != 2'h0;
          sda_hi = q_r[1];
        end
        default: sda_hi = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= !scl_hi;
      sda_oe_r <= !sda_hi;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_meta_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      sda_meta_r <= link.sda;
      sda_r <= sda_meta_r;
    end
  end

  // quarter length chooses 100 or 400 kHz
  assign tick_end = tick_r == (fast_r ? TICK_W'(FAST_QTR_CYC - 1)
                                      : TICK_W'(STD_QTR_CYC - 1));
  assign q_end = tick_end && q_r == 2'h3;
  assign op_end = q_end && (op == OP_START || op == OP_STOP || bit_r == ACK_SLOT);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_r <= '0;
      q_r <= 2'h0;
      bit_r <= CNT_RST;
    end else if (state_r != HST_RUN || tick_end) begin
      tick_r <= '0;
      q_r <= (state_r == HST_RUN) ? q_r + 2'h1 : 2'h0;
      if (state_r != HST_RUN || op_end) begin
        bit_r <= CNT_RST;
      end else if (q_end) begin
        bit_r <= bit_r + 4'h1;
      end
    end else begin
      tick_r <= tick_r + TICK_W'(1);
    end
  end

  // sampling at the end of the clock-high quarter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_r <= '0;
      nack_r <= 1'b0;
    end else if (state_r == HST_IDLE && cmd_valid) begin
      nack_r <= 1'b0;
    end else if (state_r == HST_RUN && tick_end && q_r == 2'h2) begin
      if (op == OP_RBYTE && bit_r != ACK_SLOT) begin
        rx_r <= {rx_r[6:0], sda_r};
      end
      if (op == OP_WBYTE && bit_r == ACK_SLOT && sda_r) begin
        nack_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= HST_IDLE;
      kind_r <= CMD_WRITE;
      sel_r <= '0;
      reg_r <= '0;
      data_r <= '0;
      hold_r <= 1'b0;
      fast_r <= 1'b0;
      item_r <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rd_r <= '0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        HST_IDLE: begin
          if (cmd_valid) begin
            state_r <= HST_RUN;
            kind_r <= cmd_kind;
            sel_r <= cmd_sel;
            reg_r <= cmd_reg;
            data_r <= cmd_data;
            hold_r <= cmd_hold;
            fast_r <= fast_mode;
            item_r <= 3'h0;
          end
        end
        HST_RUN: begin
          if (op_end) begin
            if (op == OP_STOP) begin
              state_r <= HST_IDLE;
              busy_r <= 1'b0;
              done_r <= 1'b1;
              rd_r <= rx_r;
            end else if (nack_r) begin
              item_r <= last;
            end else if (item_r + 3'h1 == last && hold_r) begin
              // keep the bus, clock low, for a repeated start next
              state_r <= HST_IDLE;
              busy_r <= 1'b1;
              done_r <= 1'b1;
              rd_r <= rx_r;
            end else begin
              item_r <= item_r + 3'h1;
              busy_r <= 1'b1;
            end
          end
        end
        default: state_r <= HST_IDLE;
      endcase
    end
  end

  assign done = done_r;
  assign nack = nack_r;
  assign rd_data = rd_r;

endmodule // i2cra_host_end

// ---- i2cra_pkg.sv ----
// shared constants and types for the two-wire register access link
package i2cra_pkg;

  // target address: fixed upper part, lower part from strap pins
  localparam logic [4:0] DEV_ADDR_HI = 5'h12;
  localparam int SEL_W = 2;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;

  // bit slot counter: 0..7 data bits, 8 is the acknowledge slot
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] MEM_RST = 8'h00;
  localparam int MEM_DEPTH = 256;

  // serial clock timing, derived from the system clock period
  localparam int CLK_PERIOD_NS = 5;
  localparam int STD_PERIOD_NS = 10000;
  localparam int FAST_PERIOD_NS = 2500;
  localparam int STD_QTR_CYC = STD_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int FAST_QTR_CYC = FAST_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int TICK_W = 10;

  // item index of the final stop for each command kind
  localparam logic [2:0] LAST_WRITE = 3'h4;
  localparam logic [2:0] LAST_SETPTR = 3'h3;
  localparam logic [2:0] LAST_READ = 3'h3;

  typedef enum logic [5:0] {
    DST_IDLE = 6'b000001,
    DST_ADDR = 6'b000010,
    DST_REG  = 6'b000100,
    DST_DATA = 6'b001000,
    DST_READ = 6'b010000,
    DST_SKIP = 6'b100000
  } i2cra_dev_state_t;

  typedef enum logic [1:0] {
    CMD_WRITE  = 2'h0,
    CMD_SETPTR = 2'h1,
    CMD_READ   = 2'h2
  } i2cra_cmd_t;

  typedef enum logic [3:0] {
    OP_START = 4'b0001,
    OP_WBYTE = 4'b0010,
    OP_RBYTE = 4'b0100,
    OP_STOP  = 4'b1000
  } i2cra_op_t;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b01,
    HST_RUN  = 2'b10
  } i2cra_host_state_t;

endpackage

// ---- i2cra_link_if.sv ----
// two-wire link between the bus master end and the target end
`timescale 1ns/100ps
interface i2cra_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open-drain wires with pull-up: low when any enabled driver pulls low
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport host (
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input sda
  );
  modport dev (
    input scl, sda,
    output dev_sda_o, dev_sda_oe
  );
endinterface

// ---- i2cra_dev_end.sv ----
// target end: serial register access port clocked by the link clock
`timescale 1ns/100ps

// Functional notes
// - target only, never drives serial clock
// - works at standard and fast speeds
// - data changes only while clock low
// - data fall/rise with clock high: start/stop
// - address is 10010b plus two strap bits
// - all bytes sent most significant bit first
// - master sends direction 0 for writes
// - master sends direction 1 for reads
// - acknowledge a matching address byte
// - register address byte acknowledged, loads pointer
// - next byte stored at pointer, acknowledged
// - master may repeat start for another write
// - pointer held until reset or new write
// - read shifts out pointed register, master acks
// - repeated start read uses current pointer
// - repeated start: data up, clock up, data down
// - master ends with stop, releases bus
// - target drives data only for ack/read
module i2cra_dev_end
  import i2cra_pkg::*;
(
  // system clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link side
  i2cra_link_if.dev link,
  // address strap pins
  input wire logic [SEL_W-1:0] addr_sel,
  // register write notifications, system clock domain
  output logic wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data
);

  i2cra_dev_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic [7:0] tx_r;
  logic [7:0] mem_r [MEM_DEPTH];
  logic [SEL_W-1:0] sel_meta_r;
  logic [SEL_W-1:0] sel_r;
  logic start_tg_r;
  logic stop_tg_r;
  logic start_seen_r;
  logic stop_seen_r;
  logic start_pend;
  logic stop_pend;
  logic addr_hit;
  logic ack_edge;
  logic sda_oe_r;
  logic wr_tg_r;
  logic [7:0] wr_addr_hold_r;
  logic [7:0] wr_data_hold_r;
  logic wr_meta_r;
  logic wr_sync_r;
  logic wr_prev_r;
  logic wr_valid_r;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_data_r;

  // open drain: only ever pull low; clock line is never driven
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_r;

  // start and stop are data edges while clock is high; toggles carry them
  // into the clock-edge logic, the protocol's hold times keep this safe
  always_ff @(negedge link.sda or negedge arst_n) begin
    if (!arst_n) begin
      start_tg_r <= 1'b0;
    end else if (link.scl) begin
      start_tg_r <= ~start_tg_r;
    end
  end

  always_ff @(posedge link.sda or negedge arst_n) begin
    if (!arst_n) begin
      stop_tg_r <= 1'b0;
    end else if (link.scl) begin
      stop_tg_r <= ~stop_tg_r;
    end
  end

  assign start_pend = start_tg_r != start_seen_r;
  assign stop_pend = stop_tg_r != stop_seen_r;
  assign ack_edge = cnt_r == ACK_SLOT;

  // straps pass two link-clock flops; eight edges precede the compare
  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      sel_meta_r <= '0;
      sel_r <= '0;
    end else begin
      sel_meta_r <= addr_sel;
      sel_r <= sel_meta_r;
    end
  end

  assign addr_hit = shift_r[7:1] == {DEV_ADDR_HI, sel_r};

  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else begin
      start_seen_r <= start_tg_r;
      stop_seen_r <= stop_tg_r;
    end
  end

  // sequencing on rising clock; a new start overrides everything
  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= DST_IDLE;
      cnt_r <= CNT_RST;
    end else if (start_pend) begin
      state_r <= DST_ADDR;
      cnt_r <= 4'h1;
    end else if (stop_pend) begin
      state_r <= DST_IDLE;
      cnt_r <= CNT_RST;
    end else if (state_r != DST_IDLE && state_r != DST_SKIP) begin
      if (!ack_edge) begin
        cnt_r <= cnt_r + 4'h1;
      end else begin
        cnt_r <= CNT_RST;
        case (state_r)
          DST_ADDR: begin
            if (!addr_hit) begin
              state_r <= DST_SKIP;
            end else if (shift_r[0] == RW_READ) begin
              state_r <= DST_READ;
            end else begin
              state_r <= DST_REG;
            end
          end
          DST_REG: state_r <= DST_DATA;
          // one byte per access; later bytes are not acknowledged
          DST_DATA: state_r <= DST_SKIP;
          DST_READ: state_r <= DST_SKIP;
          default: state_r <= DST_IDLE;
        endcase
      end
    end
  end

  // data sampled on rising clock, msb first
  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= '0;
    end else if (start_pend) begin
      shift_r <= {7'h00, link.sda};
    end else if (!ack_edge) begin
      shift_r <= {shift_r[6:0], link.sda};
    end
  end

  // pointer survives stops and reads; only a register address byte moves it
  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      ptr_r <= PTR_RST;
    end else if (!start_pend && !stop_pend && ack_edge && state_r == DST_REG) begin
      ptr_r <= shift_r;
    end
  end

  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= MEM_RST;
      end
      wr_tg_r <= 1'b0;
      wr_addr_hold_r <= PTR_RST;
      wr_data_hold_r <= MEM_RST;
    end else if (!start_pend && !stop_pend && ack_edge && state_r == DST_DATA) begin
      mem_r[ptr_r] <= shift_r;
      wr_tg_r <= ~wr_tg_r;
      wr_addr_hold_r <= ptr_r;
      wr_data_hold_r <= shift_r;
    end
  end

  // read data taken at the address ack from the held pointer
  always_ff @(posedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      tx_r <= MEM_RST;
    end else if (!start_pend && !stop_pend && ack_edge && state_r == DST_ADDR) begin
      tx_r <= mem_r[ptr_r];
    end
  end

  // drive only on falling clock, only for ack slots and read bits
  always_ff @(negedge link.scl or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_r <= 1'b0;
    end else if (ack_edge) begin
      sda_oe_r <= (state_r == DST_ADDR && addr_hit) || state_r == DST_REG
                  || state_r == DST_DATA;
    end else if (state_r == DST_READ) begin
      sda_oe_r <= ~tx_r[3'h7 - cnt_r[2:0]];
    end else begin
      sda_oe_r <= 1'b0;
    end
  end

  // write event crosses by toggle; hold registers stay put for many
  // link bits after the toggle, far longer than the two-flop delay
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_meta_r <= 1'b0;
      wr_sync_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end else begin
      wr_meta_r <= wr_tg_r;
      wr_sync_r <= wr_meta_r;
      wr_prev_r <= wr_sync_r;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_valid_r <= 1'b0;
      wr_addr_r <= PTR_RST;
      wr_data_r <= MEM_RST;
    end else begin
      wr_valid_r <= wr_sync_r ^ wr_prev_r;
      if (wr_sync_r ^ wr_prev_r) begin
        wr_addr_r <= wr_addr_hold_r;
        wr_data_r <= wr_data_hold_r;
      end
    end
  end

  assign wr_valid = wr_valid_r;
  assign wr_addr = wr_addr_r;
  assign wr_data = wr_data_r;

endmodule // i2cra_dev_end

// ---- i2cra_link_chk.sv ----
// assertion checker watching the two-wire link between host and target ends
`timescale 1ns/100ps
module i2cra_link_chk
  import i2cra_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link wires
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda,
  // target strap level
  input wire logic [SEL_W-1:0] addr_sel
);
  logic scl_r;
  logic sda_r;
  logic skip_r;
  logic [4:0] cnt_r;
  logic [7:0] sh_r;
  logic rise;
  logic start;
  logic stop;
  logic match;

  assign rise = scl && !scl_r;
  assign start = scl && scl_r && sda_r && !sda;
  assign stop = scl && scl_r && !sda_r && sda;
  assign match = (sh_r[7:1] == {DEV_ADDR_HI, addr_sel});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end

  // 5'h1f marks outside a frame; saturates so long frames never wrap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 5'h1f;
    end else if (start) begin
      cnt_r <= 5'h00;
    end else if (stop) begin
      cnt_r <= 5'h1f;
    end else if (rise && cnt_r < 5'h1e) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_r <= 8'h00;
    end else if (rise) begin
      sh_r <= {sh_r[6:0], sda};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_r <= 1'b0;
    end else if (start) begin
      skip_r <= 1'b0;
    end else if (rise && cnt_r == 5'h08 && !match) begin
      skip_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_scl_from_host; !scl |-> host_scl_oe; endproperty
  a_scl_from_host: assert property (p_scl_from_host)
    else $error("serial clock low while host releases it");
  property p_dev_change_low; $changed(dev_sda_oe) |-> !scl; endproperty
  a_dev_change_low: assert property (p_dev_change_low)
    else $error("target data changed with clock high");
  property p_edge_by_host;
    scl && $past(scl) && $changed(sda) |-> !dev_sda_oe && !$past(dev_sda_oe);
  endproperty
  a_edge_by_host: assert property (p_edge_by_host)
    else $error("data moved under high clock by the target");
  property p_no_contention; scl |-> !(dev_sda_oe && host_sda_oe); endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("both ends drive data in one bit");
  property p_addr_quiet; cnt_r < 5'h08 |-> !dev_sda_oe; endproperty
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("target drives data during address bits");
  property p_ack_match; rise && cnt_r == 5'h08 && match |-> !sda; endproperty
  a_ack_match: assert property (p_ack_match)
    else $error("own address not acknowledged");
  property p_nack_foreign; rise && cnt_r == 5'h08 && !match |-> sda; endproperty
  a_nack_foreign: assert property (p_nack_foreign)
    else $error("foreign address acknowledged");
  property p_skip_quiet; skip_r |-> !dev_sda_oe; endproperty
  a_skip_quiet: assert property (p_skip_quiet)
    else $error("target drives data after foreign address");
  property p_stop_idle; stop |=> (scl && sda) [*8]; endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not released after stop");
endmodule // i2cra_link_chk

// ---- i2c_register_access_slave_bench.sv ----
// self-checking bench: host end and target end joined over the link
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module i2c_register_access_slave_bench
  import i2cra_pkg::*;
;
  localparam int CYC_LIMIT = 100000;
  // clock opens high so reset can fall cleanly before the first rising edge;
  // flops clocked by the link wires see no edge of their own in reset
  logic clk = 1'b1;
  logic arst_n = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_hold = 1'b0;
  logic fast_mode = 1'b0;
  i2cra_cmd_t cmd_kind = CMD_WRITE;
  logic [SEL_W-1:0] cmd_sel = 2'h0;
  logic [SEL_W-1:0] addr_sel = 2'h3;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready;
  logic done;
  logic nack;
  logic wr_valid;
  logic [7:0] rd_data;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] abyte = 8'h00;
  int bad_count = 0;
  int checks = 0;
  int wr_cnt = 0;
  int bitn = 8;
  int cyc = 0;

  always #2.5 clk = ~clk;

  i2cra_link_if i_i2cra_link_if ();
  i2cra_host_end i_i2cra_host_end (.clk(clk), .arst_n(arst_n), .link(i_i2cra_link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_sel(cmd_sel),
    .cmd_reg(cmd_reg), .cmd_data(cmd_data), .cmd_hold(cmd_hold), .fast_mode(fast_mode),
    .done(done), .nack(nack), .rd_data(rd_data));
  i2cra_dev_end i_i2cra_dev_end (.clk(clk), .arst_n(arst_n), .link(i_i2cra_link_if),
    .addr_sel(addr_sel), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
  i2cra_link_chk i_i2cra_link_chk (.clk(clk), .arst_n(arst_n),
    .host_scl_oe(i_i2cra_link_if.host_scl_oe), .host_sda_oe(i_i2cra_link_if.host_sda_oe),
    .dev_sda_oe(i_i2cra_link_if.dev_sda_oe), .scl(i_i2cra_link_if.scl),
    .sda(i_i2cra_link_if.sda), .addr_sel(addr_sel));

  // sampled away from the launching edge to avoid a race
  always @(negedge clk) begin
    if (wr_valid === 1'b1) begin
      wr_cnt++;
    end
  end

  // wire monitor: first byte after each start, msb first
  always @(negedge i_i2cra_link_if.sda) begin
    if (i_i2cra_link_if.scl === 1'b1) begin
      bitn = 0;
    end
  end
  always @(posedge i_i2cra_link_if.scl) begin
    if (bitn < 8) begin
      abyte = {abyte[6:0], i_i2cra_link_if.sda};
      bitn++;
    end
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == CYC_LIMIT) begin
      bad_count++;
      $display("unexpected run length: expected below %0d, seen %0d", CYC_LIMIT, cyc);
      report_and_stop();
    end
  end

  task automatic run(input i2cra_cmd_t k, input logic [1:0] s, input logic [7:0] r,
                     input logic [7:0] d, input logic h, input logic f);
    int n;
    @(negedge clk);
    cmd_kind = k;
    cmd_sel = s;
    cmd_reg = r;
    cmd_data = d;
    cmd_hold = h;
    fast_mode = f;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    `CHK("ready while busy", 1'b0, cmd_ready)
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(negedge clk);
      n++;
    end
    `CHK("done", 1'b1, done)
    repeat (10) @(negedge clk);
  endtask

  task automatic verify(input string nm, input logic en, input int ew, input logic [7:0] ea);
    `CHK("nack", en, nack)
    `CHK("write count", ew, wr_cnt)
    `CHK("address byte", ea, abyte)
    `CHK("ready", 1'b1, cmd_ready)
    $display("test %s finished", nm);
  endtask

  initial begin
    @(negedge clk);
    arst_n = 1'b0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    `CHK("host clock enable", 1'b0, i_i2cra_link_if.host_scl_oe)
    `CHK("target data enable", 1'b0, i_i2cra_link_if.dev_sda_oe)
    run(CMD_WRITE, 2'h3, 8'h6d, 8'h92, 1'b1, 1'b1);
    verify("held write", 1'b0, 1, {DEV_ADDR_HI, 2'h3, RW_WRITE});
    `CHK("written pointer", 8'h6d, wr_addr)
    `CHK("written data", 8'h92, wr_data)
    run(CMD_WRITE, 2'h3, 8'h10, 8'h5a, 1'b1, 1'b1);
    verify("write after repeated start", 1'b0, 2, {DEV_ADDR_HI, 2'h3, RW_WRITE});
    `CHK("written pointer", 8'h10, wr_addr)
    `CHK("written data", 8'h5a, wr_data)
    // standard speed read straight after a repeated start
    run(CMD_READ, 2'h3, 8'h00, 8'h00, 1'b0, 1'b0);
    verify("slow read at pointer", 1'b0, 2, {DEV_ADDR_HI, 2'h3, RW_READ});
    `CHK("read data", 8'h5a, rd_data)
    `CHK("clock idle", 1'b1, i_i2cra_link_if.scl)
    `CHK("data idle", 1'b1, i_i2cra_link_if.sda)
    run(CMD_SETPTR, 2'h3, 8'h6d, 8'h00, 1'b1, 1'b1);
    verify("pointer set", 1'b0, 2, {DEV_ADDR_HI, 2'h3, RW_WRITE});
    // a foreign address must not disturb the pointer
    run(CMD_WRITE, 2'h1, 8'h10, 8'h00, 1'b0, 1'b1);
    verify("foreign address", 1'b1, 2, {DEV_ADDR_HI, 2'h1, RW_WRITE});
    // straps moved while idle: the new low address bits must be answered
    addr_sel = 2'h1;
    run(CMD_READ, 2'h1, 8'h00, 8'h00, 1'b0, 1'b1);
    verify("read after stop", 1'b0, 2, {DEV_ADDR_HI, 2'h1, RW_READ});
    `CHK("read data", 8'h92, rd_data)
    report_and_stop();
  end
endmodule // i2c_register_access_slave_bench
